/* hdl/ovw_pkg.sv */
// constants for output-voltage supervision registers and fault actions
// assumes a single 100 MHz clock domain; no file of its own uses it

package ovw_pkg;

   // ****************************************
   // command codes (register addresses)
   // ****************************************
   localparam logic [7:0] CMD_OV_ACTION  = 8'h41;
   localparam logic [7:0] CMD_HI_WARN    = 8'h42;
   localparam logic [7:0] CMD_LO_WARN    = 8'h43;
   localparam logic [7:0] CMD_UV_LIMIT   = 8'h44;
   localparam logic [7:0] CMD_UV_ACTION  = 8'h45;
   localparam logic [7:0] CMD_STATUS     = 8'he0;

   // ****************************************
   // reset values and accepted ranges
   // ****************************************
   localparam logic [15:0] RST_HI_WARN   = 16'h0151;
   localparam logic [15:0] RST_LO_WARN   = 16'h0114;
   localparam logic [15:0] RST_UV_LIMIT  = 16'h00f5;
   localparam logic [7:0]  RST_UV_ACTION = 8'hb9;
   localparam logic [7:0]  RST_OV_ACTION = 8'hf8;
   // 0.3 V and 14 V in 1.953 mV steps
   localparam logic [15:0] LIM_HI_MIN    = 16'h009a;
   localparam logic [15:0] LIM_MAX       = 16'h1c00;
   localparam logic [15:0] LIM_LO_MIN    = 16'h0000;

   // ****************************************
   // action byte fields
   // ****************************************
   localparam int ACT_MSB = 7;
   localparam int ACT_LSB = 6;
   localparam int RTY_MSB = 5;
   localparam int RTY_LSB = 3;
   localparam int DLY_MSB = 2;
   localparam int DLY_LSB = 0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   typedef enum logic [1:0] {
      ACT_CONTINUE = 2'b00,
      ACT_LATCH    = 2'b01,
      ACT_RESTART  = 2'b10,
      ACT_HOLD     = 2'b11
   } ovw_act_e;

   typedef enum logic [1:0] {
      FS_RUN  = 2'b00,
      FS_HOLD = 2'b01,
      FS_WAIT = 2'b10,
      FS_OFF  = 2'b11
   } ovw_fstate_e;

   // ****************************************
   // status bit positions
   // ****************************************
   localparam int ST_WARN_HI = 0;
   localparam int ST_WARN_LO = 1;
   localparam int ST_UV      = 2;
   localparam int ST_OV      = 3;
   localparam int ST_BADCMD  = 4;
   localparam int ST_UV_OFF  = 5;
   localparam int ST_OV_OFF  = 6;
   localparam int ST_W       = 7;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int DELAY_UNIT_US  = 20000;
   localparam int DELAY_UNIT_CYC = (DELAY_UNIT_US * 1000) / CLK_PERIOD_NS;

endpackage

/* hdl/ovw_limit_cmp.sv */
// one threshold comparator with a registered flag
// assumes sample and limit share the same output-mode scaling
`timescale 1ns/1ps
`default_nettype none

module ovw_limit_cmp #(
   parameter bit ABOVE = 1'b1,
   parameter int W     = 16
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic         sampleValid,
   input  wire logic [W-1:0] sample,
   input  wire logic [W-1:0] limit,
   output logic              flag
);

   // both operands are unsigned in the same units, so no rescaling
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         flag <= 1'b0;
      end else if (sampleValid) begin
         flag <= ABOVE ? (sample > limit) : (sample < limit);
      end
   end

endmodule
`default_nettype wire

/* hdl/ovw_fault_action.sv */
// decodes one fault action byte and decides when to shut the output
// assumes faultNow and runCmd are on clk_sys already
`timescale 1ns/1ps
`default_nettype none

module ovw_fault_action #(
   parameter int DELAY_UNIT_CYC = ovw_pkg::DELAY_UNIT_CYC,
   parameter int CNT_W          = 25
) (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       faultNow,
   input  wire logic       runCmd,
   input  wire logic [7:0] actionByte,
   output logic            outputOff,
   output logic            latchedOff
);

   ovw_pkg::ovw_fstate_e state;
   ovw_pkg::ovw_fstate_e next_state;
   ovw_pkg::ovw_act_e    act;
   logic [2:0]           retry;
   logic [2:0]           dly;
   logic [2:0]           tries;
   logic [CNT_W-1:0]     waitCnt;
   logic                 retryLeft;

   assign act   = ovw_pkg::ovw_act_e'(
                  actionByte[ovw_pkg::ACT_MSB:ovw_pkg::ACT_LSB]);
   assign retry = actionByte[ovw_pkg::RTY_MSB:ovw_pkg::RTY_LSB];
   assign dly   = actionByte[ovw_pkg::DLY_MSB:ovw_pkg::DLY_LSB];
   assign retryLeft = (retry == ovw_pkg::RETRY_FOREVER) || (tries < retry);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_state = state;
      if (!runCmd) begin
         next_state = ovw_pkg::FS_RUN;
      end else begin
         unique case (state)
            ovw_pkg::FS_RUN: begin
               if (faultNow) begin
                  unique case (act)
                     ovw_pkg::ACT_CONTINUE: next_state = ovw_pkg::FS_RUN;
                     ovw_pkg::ACT_HOLD:     next_state = ovw_pkg::FS_HOLD;
                     ovw_pkg::ACT_RESTART:  next_state = retryLeft ?
                        ovw_pkg::FS_WAIT : ovw_pkg::FS_OFF;
                     ovw_pkg::ACT_LATCH:    next_state = ovw_pkg::FS_OFF;
                  endcase
               end
            end
            ovw_pkg::FS_HOLD: begin
               // re-enable as soon as the condition clears
               if (!faultNow || act == ovw_pkg::ACT_CONTINUE) begin
                  next_state = ovw_pkg::FS_RUN;
               end
            end
            ovw_pkg::FS_WAIT: begin
               if (waitCnt == '0) begin
                  next_state = ovw_pkg::FS_RUN;
               end
            end
            ovw_pkg::FS_OFF: next_state = ovw_pkg::FS_OFF;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state      <= ovw_pkg::FS_RUN;
         outputOff  <= 1'b0;
         latchedOff <= 1'b0;
      end else begin
         state      <= next_state;
         outputOff  <= (next_state != ovw_pkg::FS_RUN);
         latchedOff <= (next_state == ovw_pkg::FS_OFF);
      end
   end

   // ****************************************
   // restart delay and attempt count
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         waitCnt <= '0;
      end else if (state != ovw_pkg::FS_WAIT
                   && next_state == ovw_pkg::FS_WAIT) begin
         waitCnt <= CNT_W'(dly * DELAY_UNIT_CYC);
      end else if (waitCnt != '0) begin
         waitCnt <= waitCnt - 1'b1;
      end
   end

   // attempts only reset on rstn or when the output is commanded off
   always_ff @(posedge clk_sys) begin
      if (!rstn || !runCmd) begin
         tries <= 3'h0;
      end else if (state == ovw_pkg::FS_RUN
                   && next_state == ovw_pkg::FS_WAIT
                   && tries != ovw_pkg::RETRY_FOREVER) begin
         tries <= tries + 3'h1;
      end
   end

endmodule
`default_nettype wire

/* hdl/ovw_regs.sv */
// output-voltage warning and fault registers with fault decisions
// assumes a command decoder on clk_sys presents one access per strobe,
// and that the sensed voltage and overvoltage flag come from this clock
//
// Functional notes
// - Response 11 with retry 111: off during fault, back on, keep retrying; code ignores retry, holds off only while fault persists.
// - Response 00: ignore the fault and keep regulating.
// - Response 11, other retry: off only while fault persists.
// - Raise high warning when sensed voltage exceeds the high threshold.
// - High threshold accepts 0.3 V to 14 V, resets to 0151h.
// - Raise low warning when sensed voltage falls below the low threshold.
// - Low threshold covers 0 V to 14 V, resets to 0114h.
// - Undervoltage fault when sensed voltage drops below the fault threshold.
// - Undervoltage threshold spans 0 V to 14 V, resets to 00F5h.
// - Undervoltage action byte: response 7:6, retry 5:3, delay 2:0, B9h.
// - Every threshold and action register reads back its last stored value.
// - Overvoltage action byte has the same layout, resets to F8h.
// - Response 10: shut down, wait 20 ms per delay step, retry.
`timescale 1ns/1ps
`default_nettype none

module ovw_regs #(
   parameter int DELAY_UNIT_CYC = ovw_pkg::DELAY_UNIT_CYC,
   parameter int VW             = 16
) (
   input  wire logic          clk_sys,
   input  wire logic          rstn,
   input  wire logic          cmdValid,
   input  wire logic          cmdWrite,
   input  wire logic [7:0]    cmdCode,
   input  wire logic [15:0]   cmdWrData,
   output logic      [15:0]   rdData,
   output logic               rdValid,
   output logic               cmdReject,
   input  wire logic          vSenseValid,
   input  wire logic [VW-1:0] vSense,
   input  wire logic          ovFaultIn,
   input  wire logic          runCmd,
   input  wire logic          biasOk,
   output logic               outputEnable,
   output logic               warnHighFlag,
   output logic               warnLowFlag,
   output logic               uvFaultFlag,
   output logic               uvShutdown,
   output logic               ovShutdown
);

   // ****************************************
   // register storage
   // ****************************************
   logic [15:0]            highWarnLimit;
   logic [15:0]            lowWarnLimit;
   logic [15:0]            uvFaultLimit;
   logic [7:0]             uvAction;
   logic [7:0]             ovAction;
   logic [ovw_pkg::ST_W-1:0] status;
   logic [ovw_pkg::ST_W-1:0] statusSet;
   logic [ovw_pkg::ST_W-1:0] statusClr;

   logic wrStrobe;
   logic rdStrobe;
   logic knownCode;
   logic wrRangeOk;
   logic wrAccept;
   logic badAccess;
   logic uvOff;
   logic ovOff;
   logic uvLatched;
   logic ovLatched;
   logic wrHigh;
   logic wrLow;
   logic wrUv;
   logic wrUvAct;
   logic wrOvAct;
   logic wrStatus;

   assign wrStrobe = cmdValid && cmdWrite;
   assign rdStrobe = cmdValid && !cmdWrite;

   // ****************************************
   // access decode
   // ****************************************

   always_comb begin
      knownCode = 1'b1;
      wrRangeOk = 1'b1;
      unique case (cmdCode)
         ovw_pkg::CMD_HI_WARN: begin
            wrRangeOk = (cmdWrData >= ovw_pkg::LIM_HI_MIN)
                        && (cmdWrData <= ovw_pkg::LIM_MAX);
         end
         ovw_pkg::CMD_LO_WARN,
         ovw_pkg::CMD_UV_LIMIT: begin
            wrRangeOk = (cmdWrData >= ovw_pkg::LIM_LO_MIN)
                        && (cmdWrData <= ovw_pkg::LIM_MAX);
         end
         ovw_pkg::CMD_OV_ACTION,
         ovw_pkg::CMD_UV_ACTION,
         ovw_pkg::CMD_STATUS: wrRangeOk = 1'b1;
         default: knownCode = 1'b0;
      endcase
   end

   // out-of-range or unknown writes are dropped, never clipped
   assign wrAccept  = wrStrobe && knownCode && wrRangeOk;
   assign badAccess = cmdValid && (!knownCode || (cmdWrite && !wrRangeOk));

   // ****************************************
   // per-register write enables
   // ****************************************
   assign wrHigh   = wrAccept && (cmdCode == ovw_pkg::CMD_HI_WARN);
   assign wrLow    = wrAccept && (cmdCode == ovw_pkg::CMD_LO_WARN);
   assign wrUv     = wrAccept && (cmdCode == ovw_pkg::CMD_UV_LIMIT);
   assign wrUvAct  = wrAccept && (cmdCode == ovw_pkg::CMD_UV_ACTION);
   assign wrOvAct  = wrAccept && (cmdCode == ovw_pkg::CMD_OV_ACTION);
   assign wrStatus = wrAccept && (cmdCode == ovw_pkg::CMD_STATUS);

   // ****************************************
   // threshold registers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         highWarnLimit <= ovw_pkg::RST_HI_WARN;
      end else if (wrHigh) begin
         highWarnLimit <= cmdWrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         lowWarnLimit <= ovw_pkg::RST_LO_WARN;
      end else if (wrLow) begin
         lowWarnLimit <= cmdWrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         uvFaultLimit <= ovw_pkg::RST_UV_LIMIT;
      end else if (wrUv) begin
         uvFaultLimit <= cmdWrData;
      end
   end

   // ****************************************
   // action bytes
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         uvAction <= ovw_pkg::RST_UV_ACTION;
      end else if (wrUvAct) begin
         uvAction <= cmdWrData[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ovAction <= ovw_pkg::RST_OV_ACTION;
      end else if (wrOvAct) begin
         ovAction <= cmdWrData[7:0];
      end
   end

   // ****************************************
   // comparators
   // ****************************************
   ovw_limit_cmp #(
      .ABOVE (1'b1),
      .W     (VW)
   ) u_cmpHigh (
      .clk_sys     (clk_sys),
      .rstn        (rstn),
      .sampleValid (vSenseValid),
      .sample      (vSense),
      .limit       (highWarnLimit[VW-1:0]),
      .flag        (warnHighFlag)
   );

   ovw_limit_cmp #(
      .ABOVE (1'b0),
      .W     (VW)
   ) u_cmpLow (
      .clk_sys     (clk_sys),
      .rstn        (rstn),
      .sampleValid (vSenseValid),
      .sample      (vSense),
      .limit       (lowWarnLimit[VW-1:0]),
      .flag        (warnLowFlag)
   );

   ovw_limit_cmp #(
      .ABOVE (1'b0),
      .W     (VW)
   ) u_cmpUv (
      .clk_sys     (clk_sys),
      .rstn        (rstn),
      .sampleValid (vSenseValid),
      .sample      (vSense),
      .limit       (uvFaultLimit[VW-1:0]),
      .flag        (uvFaultFlag)
   );

   // ****************************************
   // fault actions
   // ****************************************
   ovw_fault_action #(
      .DELAY_UNIT_CYC (DELAY_UNIT_CYC)
   ) u_uvAction (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .faultNow   (uvFaultFlag),
      .runCmd     (runCmd),
      .actionByte (uvAction),
      .outputOff  (uvOff),
      .latchedOff (uvLatched)
   );

   ovw_fault_action #(
      .DELAY_UNIT_CYC (DELAY_UNIT_CYC)
   ) u_ovAction (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .faultNow   (ovFaultIn),
      .runCmd     (runCmd),
      .actionByte (ovAction),
      .outputOff  (ovOff),
      .latchedOff (ovLatched)
   );

   // ****************************************
   // output control
   // ****************************************
   // losing bias or command drops the output regardless of fault state
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         outputEnable <= 1'b0;
         uvShutdown   <= 1'b0;
         ovShutdown   <= 1'b0;
      end else begin
         outputEnable <= runCmd && biasOk && !uvOff && !ovOff;
         uvShutdown   <= uvOff;
         ovShutdown   <= ovOff;
      end
   end

   // ****************************************
   // sticky status, write one to clear
   // ****************************************
   always_comb begin
      statusSet = '0;
      statusSet[ovw_pkg::ST_WARN_HI] = warnHighFlag;
      statusSet[ovw_pkg::ST_WARN_LO] = warnLowFlag;
      statusSet[ovw_pkg::ST_UV]      = uvFaultFlag;
      statusSet[ovw_pkg::ST_OV]      = ovFaultIn;
      statusSet[ovw_pkg::ST_BADCMD]  = badAccess;
      statusSet[ovw_pkg::ST_UV_OFF]  = uvLatched;
      statusSet[ovw_pkg::ST_OV_OFF]  = ovLatched;
   end

   assign statusClr = wrStatus
                      ? cmdWrData[ovw_pkg::ST_W-1:0] : '0;

   // bits: 0 high warn, 1 low warn, 2 uv fault, 3 ov fault,
   // 4 bad access, 5 uv latched off, 6 ov latched off
   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         status <= '0;
      end else begin
         status <= (status & ~statusClr) | statusSet;
      end
   end

   // ****************************************
   // read back
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdData <= 16'h0000;
      end else if (rdStrobe) begin
         unique case (cmdCode)
            ovw_pkg::CMD_HI_WARN:   rdData <= highWarnLimit;
            ovw_pkg::CMD_LO_WARN:   rdData <= lowWarnLimit;
            ovw_pkg::CMD_UV_LIMIT:  rdData <= uvFaultLimit;
            ovw_pkg::CMD_UV_ACTION: rdData <= {8'h00, uvAction};
            ovw_pkg::CMD_OV_ACTION: rdData <= {8'h00, ovAction};
            ovw_pkg::CMD_STATUS:
               rdData <= {{(16 - ovw_pkg::ST_W){1'b0}}, status};
            default:                rdData <= 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdValid   <= 1'b0;
         cmdReject <= 1'b0;
      end else begin
         rdValid   <= rdStrobe;
         cmdReject <= badAccess;
      end
   end

endmodule
`default_nettype wire

/* tb/ovw_regs_props.sv */
// checker for the voltage supervision register block
// assumes it is bound to ovw_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module ovw_regs_props (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        cmdValid,
   input wire logic        cmdWrite,
   input wire logic [15:0] rdData,
   input wire logic        rdValid,
   input wire logic        cmdReject,
   input wire logic        vSenseValid,
   input wire logic        ovFaultIn,
   input wire logic        runCmd,
   input wire logic        biasOk,
   input wire logic        outputEnable,
   input wire logic        warnHighFlag,
   input wire logic        warnLowFlag,
   input wire logic        uvFaultFlag,
   input wire logic        uvShutdown,
   input wire logic        ovShutdown
);
   // ********************
   // properties
   // ********************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_read_answer: assert property (
      cmdValid && !cmdWrite |=> rdValid) else $error("read not answered");
   a_rdata_hold: assert property (
      !(cmdValid && !cmdWrite) |=> $stable(rdData))
      else $error("read data moved without a read");
   a_reject_cause: assert property (
      cmdReject |-> $past(cmdValid)) else $error("reject without access");
   a_flags_hold: assert property (
      !vSenseValid |=> $stable({warnHighFlag, warnLowFlag, uvFaultFlag}))
      else $error("flag moved without a sample");
   // shutdown shows two edges after the fault that caused it
   a_ov_cause: assert property (
      $rose(ovShutdown) |-> $past(ovFaultIn, 2))
      else $error("ov off no fault");
   a_uv_cause: assert property (
      $rose(uvShutdown) |-> $past(uvFaultFlag, 2))
      else $error("uv off no fault");
   // shutdown and enable leave the same edge
   a_uv_output_off: assert property (
      uvShutdown |-> !outputEnable) else $error("output on during uv off");
   a_ov_output_off: assert property (
      ovShutdown |-> !outputEnable) else $error("output on during ov off");
   a_cmd_output_off: assert property (
      !(runCmd && biasOk) |=> !outputEnable) else $error("output on when off");
   a_enable_on: assert property (
      $past(rstn) && $past(runCmd && biasOk)
      && !uvShutdown && !ovShutdown |-> outputEnable)
      else $error("output stays off");
endmodule

bind ovw_regs ovw_regs_props ovw_regs_props_inst (
   .clk_sys(clk_sys), .rstn(rstn), .cmdValid(cmdValid),
   .cmdWrite(cmdWrite), .rdData(rdData), .rdValid(rdValid),
   .cmdReject(cmdReject), .vSenseValid(vSenseValid), .ovFaultIn(ovFaultIn),
   .runCmd(runCmd), .biasOk(biasOk), .outputEnable(outputEnable),
   .warnHighFlag(warnHighFlag), .warnLowFlag(warnLowFlag),
   .uvFaultFlag(uvFaultFlag), .uvShutdown(uvShutdown),
   .ovShutdown(ovShutdown));
`default_nettype wire

/* tb/ovw_host_model.sv */
// host model driving the register access port
// assumes calls start just after a rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none

module ovw_host_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] rdData,
   input  wire logic        rdValid,
   input  wire logic        cmdReject,
   output var logic         cmdValid,
   output var logic         cmdWrite,
   output var logic [7:0]   cmdCode,
   output var logic [15:0]  cmdWrData
);
   logic [15:0] lastRd;
   logic        lastVal;
   logic        lastRej;

   initial begin
      cmdValid  = 1'b0;
      cmdWrite  = 1'b0;
      cmdCode   = 8'h00;
      cmdWrData = 16'h0000;
   end

   // ********************
   // one access
   // ********************
   task automatic access(input logic wr, input logic [7:0] code,
                         input logic [15:0] data);
      cmdValid  = 1'b1;
      cmdWrite  = wr;
      cmdCode   = code;
      cmdWrData = data;
      @(posedge clk_sys);
      #1;
      lastRd    = rdData;
      lastVal   = rdValid;
      lastRej   = cmdReject;
      cmdValid  = 1'b0;
      // idle bus must not look like the last request
      cmdCode   = ~code;
      cmdWrData = ~data;
      // one idle edge keeps back-to-back calls apart
      @(posedge clk_sys);
      #1;
   endtask
endmodule
`default_nettype wire

/* tb/ovw_regs_tb.sv */
// self-checking bench for the voltage supervision registers
// assumes the host model issues one access at a time
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
   begin \
      cmpCount++; \
      if ((got) !== (exp)) begin \
         errorCnt++; \
         $display("wrong value %s expected %h seen %h", nm, exp, got); \
      end \
   end

module ovw_regs_tb;
   // short delay unit keeps the retry wait a few cycles long
   localparam int UNIT = 20;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        cmdValid, cmdWrite, rdValid, cmdReject;
   logic [7:0]  cmdCode;
   logic [15:0] cmdWrData, rdData;
   logic        vSenseValid = 1'b0;
   logic [15:0] vSense = 16'h0130;
   logic        ovFaultIn = 1'b0;
   logic        runCmd = 1'b1;
   logic        biasOk = 1'b1;
   logic        outputEnable, warnHighFlag, warnLowFlag, uvFaultFlag;
   logic        uvShutdown, ovShutdown;
   int          errorCnt = 0;
   int          cmpCount = 0;
   int          i;
   logic [7:0]  ovCodes [4] = '{8'hf8, 8'hc0, 8'h00, 8'h16};
   logic [15:0] sv [5] = '{16'h0201, 16'h0200, 16'h0100, 16'h00ff, 16'h0080};
   logic [2:0]  sf [5] = '{3'b100, 3'b000, 3'b000, 3'b010, 3'b010};

   ovw_regs #(.DELAY_UNIT_CYC(UNIT)) ovw_regs_inst (
      .clk_sys(clk_sys), .rstn(rstn), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
      .rdData(rdData), .rdValid(rdValid), .cmdReject(cmdReject),
      .vSenseValid(vSenseValid), .vSense(vSense), .ovFaultIn(ovFaultIn),
      .runCmd(runCmd), .biasOk(biasOk), .outputEnable(outputEnable),
      .warnHighFlag(warnHighFlag), .warnLowFlag(warnLowFlag),
      .uvFaultFlag(uvFaultFlag), .uvShutdown(uvShutdown),
      .ovShutdown(ovShutdown));

   ovw_host_model ovw_host_model_inst (
      .clk_sys(clk_sys), .rdData(rdData), .rdValid(rdValid),
      .cmdReject(cmdReject), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
      .cmdCode(cmdCode), .cmdWrData(cmdWrData));

   always #5 clk_sys = ~clk_sys;

   // ********************
   // helpers
   // ********************
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      ovw_host_model_inst.access(1'b0, code, 16'h0000);
      `CHK("read valid", 1'b1, ovw_host_model_inst.lastVal)
      `CHK("read data", exp, ovw_host_model_inst.lastRd)
   endtask

   task automatic wr(input logic [7:0] code, input logic [15:0] d,
                     input logic rej);
      ovw_host_model_inst.access(1'b1, code, d);
      `CHK("reject", rej, ovw_host_model_inst.lastRej)
   endtask

   task automatic sample(input logic [15:0] v);
      vSense = v;
      vSenseValid = 1'b1;
      step(1);
      vSenseValid = 1'b0;
      vSense = ~v;
      step(1);
   endtask

   task automatic completeRun;
      $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
      if (errorCnt == 0 && cmpCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #200000;
      errorCnt++;
      completeRun();
   end

   // ********************
   // tests
   // ********************
   initial begin
      step(6);
      rstn = 1'b1;
      rd(8'h41, 16'h00f8);
      rd(8'h42, 16'h0151);
      rd(8'h43, 16'h0114);
      rd(8'h44, 16'h00f5);
      rd(8'h45, 16'h00b9);
      `CHK("enable", 1'b1, outputEnable)
      $display("test reset_values done");
      wr(8'h42, 16'h1c00, 1'b0);
      wr(8'h42, 16'h0099, 1'b1);
      rd(8'h42, 16'h1c00);
      wr(8'h43, 16'h1c01, 1'b1);
      wr(8'h44, 16'h0000, 1'b0);
      rd(8'h44, 16'h0000);
      wr(8'h45, 16'h00c7, 1'b0);
      rd(8'h45, 16'h00c7);
      wr(8'h50, 16'h1234, 1'b1);
      $display("test access_bounds done");
      wr(8'h42, 16'h0200, 1'b0);
      wr(8'h43, 16'h0100, 1'b0);
      wr(8'h44, 16'h0080, 1'b0);
      wr(8'h45, 16'h00b9, 1'b0);
      for (i = 0; i < 5; i++) begin
         sample(sv[i]);
         `CHK("high flag", sf[i][2], warnHighFlag)
         `CHK("low flag", sf[i][1], warnLowFlag)
         `CHK("uv flag", sf[i][0], uvFaultFlag)
      end
      $display("test thresholds done");
      sample(16'h007f);
      `CHK("uv flag", 1'b1, uvFaultFlag)
      step(2);
      `CHK("uv off", 1'b0, outputEnable)
      `CHK("uv shut", 1'b1, uvShutdown)
      sample(16'h0180);
      step(5);
      `CHK("uv wait", 1'b0, outputEnable)
      step(30);
      `CHK("uv retry", 1'b1, outputEnable)
      `CHK("uv shut end", 1'b0, uvShutdown)
      $display("test uv_retry done");
      for (i = 0; i < 4; i++) begin
         wr(8'h41, {8'h00, ovCodes[i]}, 1'b0);
         ovFaultIn = 1'b1;
         step(3);
         `CHK("ov enable", ovCodes[i][7:6] != 2'b11, outputEnable)
         `CHK("ov shut", ovCodes[i][7:6] == 2'b11, ovShutdown)
         ovFaultIn = 1'b0;
         step(3);
         `CHK("ov recover", 1'b1, outputEnable)
      end
      // response 01 stays off after the fault until run drops
      wr(8'h41, 16'h0040, 1'b0);
      ovFaultIn = 1'b1;
      step(3);
      ovFaultIn = 1'b0;
      step(3);
      `CHK("ov latched", 1'b0, outputEnable)
      $display("test ov_actions done");
      for (i = 0; i < 2; i++) begin
         {runCmd, biasOk} = (i == 0) ? 2'b01 : 2'b10;
         step(2);
         `CHK("cmd off", 1'b0, outputEnable)
         {runCmd, biasOk} = 2'b11;
         step(2);
         `CHK("cmd on", 1'b1, outputEnable)
      end
      $display("test run_control done");
      rd(8'he0, 16'h005f);
      wr(8'he0, 16'hffff, 1'b0);
      rd(8'he0, 16'h0000);
      $display("test status done");
      completeRun();
   end
endmodule
`default_nettype wire
